// ===== core/tbm_pkg.sv
// Constants, field layouts and carrier types of the temperature and battery monitor
package tbm_pkg;

   // Register offsets (7-bit register address space)
   localparam logic [6:0] ADDR_CONV_CFG = 7'h0F;
   localparam logic [6:0] ADDR_CONV_VALUE = 7'h11;
   localparam logic [6:0] ADDR_TEMP_CTL = 7'h12;
   localparam logic [6:0] ADDR_TEMP_OFFS = 7'h13;
   localparam logic [6:0] ADDR_BAT_THRESH = 7'h1A;
   localparam logic [6:0] ADDR_BAT_LEVEL = 7'h1B;

   // Reset values
   localparam logic [7:0] RST_CONV_CFG = 8'h00;
   localparam logic [7:0] RST_TEMP_CTL = 8'h20;
   localparam logic [7:0] RST_TEMP_OFFS = 8'h00;
   localparam logic [4:0] RST_BAT_THRESH = 5'h14;
   localparam logic [4:0] RST_BAT_LEVEL = 5'h00;
   localparam logic [7:0] RST_CONV_VALUE = 8'h00;

   // Field positions
   localparam int CONV_START_BIT = 7;
   localparam int TS_SHIFT_BIT = 5;
   localparam int SPI_WRITE_BIT = 7;
   localparam logic [2:0] SEL_TEMP = 3'h0;

   // Timing
   localparam longint unsigned CLK_HZ = 64'd25_000_000;
   localparam longint unsigned CONV_TIME_US = 64'd350;
   localparam longint unsigned MEAS_PERIOD_MS = 64'd1000;
   localparam longint unsigned MEAS_WINDOW_US = 64'd250;
   localparam longint unsigned CONV_CYC = (CONV_TIME_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
   localparam longint unsigned MEAS_PERIOD_CYC = (MEAS_PERIOD_MS * CLK_HZ) / 64'd1_000;
   localparam longint unsigned MEAS_WINDOW_CYC = (MEAS_WINDOW_US * CLK_HZ) / 64'd1_000_000;
   localparam logic [2:0] BAT_LOW_READS = 3'h4;

   // Temperature sensor control, laid out as the register byte
   typedef struct packed {
      logic [1:0] range;
      logic shift_enable;
      logic trim_enable;
      logic [1:0] trim;
      logic [1:0] ref_trim;
   } tbm_temp_cfg_t;

   // General converter configuration, laid out as the register byte
   typedef struct packed {
      logic busy;
      logic [2:0] sel;
      logic [1:0] ref_sel;
      logic [1:0] gain;
   } tbm_conv_cfg_t;

endpackage

// ===== core/tbm_battery.sv
// Periodic battery level measurement and low-battery interrupt
`timescale 1ns/10ps
module tbm_battery import tbm_pkg::*; #(
   parameter int unsigned PERIOD_CYCLES = 32'(MEAS_PERIOD_CYC),
   parameter int unsigned WINDOW_CYCLES = 32'(MEAS_WINDOW_CYC)
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic irq_enable,
   input wire logic sleep_mode,
   input wire logic [4:0] threshold,
   input wire logic [4:0] level_raw,
   output logic [4:0] level,
   output logic meas_power,
   output logic rc_osc_enable,
   output logic irq_out_n
);
   localparam int PW = $clog2(PERIOD_CYCLES);
   localparam int WW = $clog2(WINDOW_CYCLES + 1);

   logic [PW-1:0] period_cnt;
   logic [WW-1:0] win_cnt;
   logic [2:0] low_cnt;

   wire period_wrap = (period_cnt == PW'(PERIOD_CYCLES - 1));
   wire sample = meas_power && (win_cnt == WW'(WINDOW_CYCLES - 1));
   wire below = (level_raw < threshold);
   wire [2:0] next_low_cnt = !below ? 3'h0 : (low_cnt == BAT_LOW_READS) ? low_cnt : low_cnt + 3'h1;
   wire [2:0] next_cnt_used = sample ? next_low_cnt : low_cnt;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         period_cnt <= '0;
         win_cnt <= '0;
         meas_power <= 1'b0;
         low_cnt <= 3'h0;
         level <= RST_BAT_LEVEL;
      end else if (!enable) begin
         // Idle while disabled; the detector is kept unpowered
         period_cnt <= '0; // [RULE9]
         win_cnt <= '0;
         meas_power <= 1'b0;
         low_cnt <= 3'h0; // [RULE15]
      end else begin
         period_cnt <= period_wrap ? '0 : period_cnt + PW'(1);
         if (period_cnt == '0) begin
            meas_power <= 1'b1; // [RULE11]
            win_cnt <= '0;
         end else if (sample) begin
            meas_power <= 1'b0; // [RULE11]
         end else if (meas_power) begin
            win_cnt <= win_cnt + WW'(1);
         end
         if (sample) begin
            level <= level_raw; // [RULE13] [RULE9]
            low_cnt <= next_low_cnt; // [RULE12] [RULE15]
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rc_osc_enable <= 1'b0;
         irq_out_n <= 1'b1;
      end else begin
         rc_osc_enable <= enable && sleep_mode; // [RULE10]
         irq_out_n <= !(enable && irq_enable && next_cnt_used == BAT_LOW_READS); // [RULE7] [RULE12]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_irq_four_reads: assert property (!irq_out_n |-> low_cnt == BAT_LOW_READS) // [RULE12]
      else $error("Interrupt without four low readings");
   a_irq_gated_enables: assert property (!irq_out_n |-> $past(enable) && $past(irq_enable)) // [RULE7]
      else $error("Interrupt while monitor or interrupt disabled");
   a_count_clear_high: assert property (enable && sample && !below |=> low_cnt == 3'h0) // [RULE15]
      else $error("Low count not cleared by a good reading");
   a_disabled_idle: assert property (!enable |=> !meas_power && low_cnt == 3'h0 && irq_out_n) // [RULE9]
      else $error("Monitor active while disabled");
   a_rc_osc_sleep: assert property (enable && sleep_mode |=> rc_osc_enable) // [RULE10]
      else $error("RC oscillator not started in sleep");
   a_level_capture: assert property (enable && sample |=> level == $past(level_raw)) // [RULE13]
      else $error("Battery level not captured");
   c_low_battery_irq: cover property ($fell(irq_out_n));
   c_good_after_low: cover property (low_cnt == BAT_LOW_READS ##1 low_cnt == 3'h0);

endmodule

// ===== core/tbm_top.sv
// Temperature sensor and battery monitor control with serial register access
//
// What this block does
// [RULE1] Sensor powered when selected, no enable needed
// [RULE2] Host selects sensor, bandgap, range, offset, start
// [RULE3] Two-bit range field picks span and resolution
// [RULE4] Shift disabled gives absolute kelvin test mode
// [RULE5] Offset enable adds offset register to result
// [RULE6] Trim enable applies analogue sensor trim field
// [RULE7] Low level under threshold asserts interrupt
// [RULE8] Host reads status registers to find cause; none are held here, and status address 7'h03 reads 8'h00
// [RULE9] Monitor runs only when enabled; level readable
// [RULE10] Sleep with monitor on starts RC oscillator
// [RULE11] Detector powered each second for 250 us
// [RULE12] Four consecutive low readings before interrupt
// [RULE13] Level code is 50 mV steps from 1.7 V
// [RULE14] Start bit reads busy, clears after 350 us
// [RULE15] Good reading or disable clears low count
// [RULE16] Level register upper bits zero, writes ignored
`timescale 1ns/10ps
module tbm_top import tbm_pkg::*; #(
   parameter int unsigned CONV_CYCLES = 32'(CONV_CYC),
   parameter int unsigned PERIOD_CYCLES = 32'(MEAS_PERIOD_CYC),
   parameter int unsigned WINDOW_CYCLES = 32'(MEAS_WINDOW_CYC)
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic spi_sck,
   input wire logic spi_nsel,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   input wire logic [7:0] conv_raw,
   input wire logic [4:0] bat_raw,
   input wire logic test_bus_temp_sel,
   input wire logic battery_monitor_enable,
   input wire logic battery_irq_enable,
   input wire logic sleep_mode,
   output tbm_conv_cfg_t conv_cfg,
   output logic conv_start,
   output tbm_temp_cfg_t temp_cfg,
   output logic temp_sensor_power,
   output logic battery_power,
   output logic rc_osc_enable,
   output logic irq_out_n
);
   localparam int CW = $clog2(CONV_CYCLES + 1);

   logic [2:0] sck_s;
   logic [1:0] nsel_s;
   logic [1:0] sdi_s;
   logic [7:0] conv_raw_s0, conv_raw_s1;
   logic [4:0] bat_raw_s0, bat_raw_s1;
   logic [7:0] shift_in;
   logic [2:0] bit_cnt;
   logic first_byte;
   logic is_write;
   logic [6:0] addr;
   logic [7:0] sdo_sh;
   logic [7:0] temp_offs;
   logic [4:0] bat_thresh;
   logic [4:0] bat_level;
   logic [7:0] conv_value;
   logic [CW-1:0] conv_cnt;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
      logic [8:0] s;
      s = {1'b0, a} + {1'b0, b};
      return s[8] ? 8'hFF : s[7:0];
   endfunction

   function automatic logic [7:0] reg_read(input logic [6:0] a, input tbm_conv_cfg_t cc,
                                           input logic [7:0] cv, input tbm_temp_cfg_t tc,
                                           input logic [7:0] to, input logic [4:0] th,
                                           input logic [4:0] lv);
      case (a)
         ADDR_CONV_CFG: return cc;
         ADDR_CONV_VALUE: return cv;
         ADDR_TEMP_CTL: return tc;
         ADDR_TEMP_OFFS: return to;
         ADDR_BAT_THRESH: return {3'h0, th};
         ADDR_BAT_LEVEL: return {3'h0, lv}; // [RULE16]
         default: return 8'h00;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sck_s <= 3'h0;
         nsel_s <= 2'h3;
         sdi_s <= 2'h0;
         conv_raw_s0 <= 8'h00;
         conv_raw_s1 <= 8'h00;
         bat_raw_s0 <= 5'h00;
         bat_raw_s1 <= 5'h00;
      end else begin
         sck_s <= {sck_s[1:0], spi_sck};
         nsel_s <= {nsel_s[0], spi_nsel};
         sdi_s <= {sdi_s[0], spi_sdi};
         conv_raw_s0 <= conv_raw;
         conv_raw_s1 <= conv_raw_s0;
         bat_raw_s0 <= bat_raw;
         bat_raw_s1 <= bat_raw_s0;
      end
   end

   wire selected = !nsel_s[1];
   wire sck_rise = sck_s[1] && !sck_s[2];
   wire sck_fall = !sck_s[1] && sck_s[2];
   wire [7:0] next_byte = {shift_in[6:0], sdi_s[1]};
   wire byte_done = selected && sck_rise && (bit_cnt == 3'h7);
   wire wr_en = byte_done && !first_byte && is_write;
   wire [6:0] next_addr = first_byte ? next_byte[6:0] : addr + 7'h01;
   wire [7:0] rd_data = reg_read(next_addr, conv_cfg, conv_value, temp_cfg, temp_offs, bat_thresh, bat_level);
   wire conv_go = wr_en && (addr == ADDR_CONV_CFG) && next_byte[CONV_START_BIT] && !conv_cfg.busy;
   wire conv_end = conv_cfg.busy && (conv_cnt == CW'(CONV_CYCLES - 1));
   wire [7:0] conv_result = temp_cfg.shift_enable ? sat_add(conv_raw_s1, temp_offs) : conv_raw_s1;

   ////////////////////////////////////////////////////////////////////////////
   // Serial slave: command byte (write flag, address), then data bytes with auto-increment
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         shift_in <= 8'h00;
         bit_cnt <= 3'h0;
         first_byte <= 1'b1;
         is_write <= 1'b0;
         addr <= 7'h00;
         sdo_sh <= 8'h00;
         spi_sdo <= 1'b0;
         spi_sdo_oe <= 1'b0;
      end else if (!selected) begin
         bit_cnt <= 3'h0;
         first_byte <= 1'b1;
         spi_sdo_oe <= 1'b0;
      end else begin
         spi_sdo_oe <= 1'b1;
         if (sck_rise) begin
            shift_in <= next_byte;
            bit_cnt <= bit_cnt + 3'h1;
         end
         if (byte_done) begin
            first_byte <= 1'b0;
            addr <= next_addr;
            sdo_sh <= rd_data;
            if (first_byte) begin
               is_write <= next_byte[SPI_WRITE_BIT];
            end
         end else if (sck_fall) begin
            spi_sdo <= sdo_sh[7];
            sdo_sh <= {sdo_sh[6:0], 1'b0};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file and general converter sequencing
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cfg <= RST_CONV_CFG;
         temp_cfg <= RST_TEMP_CTL; // [RULE4]
         temp_offs <= RST_TEMP_OFFS;
         bat_thresh <= RST_BAT_THRESH;
      end else begin
         if (wr_en && addr == ADDR_CONV_CFG) begin
            conv_cfg.sel <= next_byte[6:4];
            conv_cfg.ref_sel <= next_byte[3:2];
            conv_cfg.gain <= next_byte[1:0];
         end
         if (conv_go) begin
            conv_cfg.busy <= 1'b1; // [RULE14]
         end else if (conv_end) begin
            conv_cfg.busy <= 1'b0; // [RULE14]
         end
         if (wr_en && addr == ADDR_TEMP_CTL) begin
            temp_cfg <= next_byte; // [RULE3] [RULE6]
         end
         if (wr_en && addr == ADDR_TEMP_OFFS) begin
            temp_offs <= next_byte;
         end
         if (wr_en && addr == ADDR_BAT_THRESH) begin
            bat_thresh <= next_byte[4:0];
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         conv_cnt <= '0;
         conv_value <= RST_CONV_VALUE;
         conv_start <= 1'b0;
         temp_sensor_power <= 1'b0;
      end else begin
         conv_start <= conv_go;
         conv_cnt <= conv_go ? '0 : conv_cfg.busy ? conv_cnt + CW'(1) : conv_cnt;
         if (conv_end) begin
            conv_value <= conv_result; // [RULE5] [RULE4] [RULE2]
         end
         temp_sensor_power <= (conv_cfg.sel == SEL_TEMP) || test_bus_temp_sel; // [RULE1]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   tbm_battery #(
      .PERIOD_CYCLES(PERIOD_CYCLES),
      .WINDOW_CYCLES(WINDOW_CYCLES)
   ) u_battery (
      .mclk(mclk),
      .rst_n(rst_n),
      .enable(battery_monitor_enable),
      .irq_enable(battery_irq_enable),
      .sleep_mode(sleep_mode),
      .threshold(bat_thresh),
      .level_raw(bat_raw_s1),
      .level(bat_level),
      .meas_power(battery_power),
      .rc_osc_enable(rc_osc_enable),
      .irq_out_n(irq_out_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   logic [CW:0] busy_len;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         busy_len <= '0;
      end else begin
         busy_len <= conv_cfg.busy ? busy_len + (CW + 1)'(1) : '0;
      end
   end

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_sensor_power_sel: assert property (conv_cfg.sel == SEL_TEMP |=> temp_sensor_power) // [RULE1]
      else $error("Sensor not powered while selected");
   a_sensor_power_off: assert property (conv_cfg.sel != SEL_TEMP && !test_bus_temp_sel |=> !temp_sensor_power) // [RULE1]
      else $error("Sensor powered while not selected");
   a_start_sets_busy: assert property (conv_go |=> conv_cfg.busy && conv_start ##1 !conv_start) // [RULE14]
      else $error("Start did not set busy with one start pulse");
   a_busy_length: assert property ($fell(conv_cfg.busy) |-> $past(busy_len) == (CW + 1)'(CONV_CYCLES - 1)) // [RULE14]
      else $error("Conversion time wrong");
   a_offset_added: assert property (conv_end && temp_cfg.shift_enable |=> // [RULE5]
                                    conv_value == sat_add($past(conv_raw_s1), $past(temp_offs)))
      else $error("Offset not added to result");
   a_absolute_raw: assert property (conv_end && !temp_cfg.shift_enable |=> conv_value == $past(conv_raw_s1)) // [RULE4]
      else $error("Absolute mode result altered");
   // A write to the level register must not move it; only a measurement may
   a_level_upper_zero: assert property ((byte_done && next_addr == ADDR_BAT_LEVEL) || // [RULE16]
                                        (wr_en && addr == ADDR_BAT_LEVEL) |=>
                                        sdo_sh[7:5] == 3'h0 && ($stable(bat_level) || $past(battery_power)))
      else $error("Level register upper bits not zero");
   c_conversion_done: cover property ($fell(conv_cfg.busy));
   c_temp_ctl_write: cover property (wr_en && addr == ADDR_TEMP_CTL);
   c_burst_write: cover property (wr_en ##[1:200] wr_en);

endmodule

// ===== bench/tbm_host.sv
// Host microcontroller model driving the serial register port
`timescale 1ns/10ps
module tbm_host (
   input wire logic mclk,
   input wire logic miso,
   output logic spi_sck,
   output logic spi_nsel,
   output logic spi_sdi
);
   localparam int HALF = 6;
   initial begin
      spi_sck = 1'b0;
      spi_nsel = 1'b1;
      spi_sdi = 1'b0;
   end
   task automatic wait_clk(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // Mode 0, MSB first; read data taken at each sck rise
   task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         spi_sdi = tx[i];
         wait_clk(HALF);
         rx[i] = miso;
         spi_sck = 1'b1;
         wait_clk(HALF);
         spi_sck = 1'b0;
      end
   endtask
   // Command byte then one data byte; released sdi shows no stale value
   task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
      logic [7:0] unused;
      wait_clk(1);
      spi_nsel = 1'b0;
      shift_byte(cmd, unused);
      shift_byte(wd, rd);
      wait_clk(HALF);
      spi_nsel = 1'b1;
      spi_sdi = ~spi_sdi;
      wait_clk(HALF);
   endtask
   // Command byte then two data bytes at consecutive addresses
   task automatic frame2(input logic [7:0] cmd, input logic [7:0] wd0, input logic [7:0] wd1,
                         output logic [7:0] rd0, output logic [7:0] rd1);
      logic [7:0] unused;
      wait_clk(1);
      spi_nsel = 1'b0;
      shift_byte(cmd, unused);
      shift_byte(wd0, rd0);
      shift_byte(wd1, rd1);
      wait_clk(HALF);
      spi_nsel = 1'b1;
      spi_sdi = ~spi_sdi;
      wait_clk(HALF);
   endtask
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the temperature and battery monitor
`timescale 1ns/10ps
module tb_top;
   import tbm_pkg::*;
   localparam int CONV = 600;
   localparam int PER = 64;
   localparam int WIN = 8;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic spi_sck, spi_nsel, spi_sdi, spi_sdo, spi_sdo_oe;
   logic [7:0] conv_raw = 8'h00;
   logic [4:0] bat_raw = 5'h00;
   logic test_bus_temp_sel = 1'b0;
   logic battery_monitor_enable = 1'b0;
   logic battery_irq_enable = 1'b0;
   logic sleep_mode = 1'b0;
   tbm_conv_cfg_t conv_cfg;
   tbm_temp_cfg_t temp_cfg;
   logic conv_start, temp_sensor_power, battery_power, rc_osc_enable, irq_out_n;
   int num_errors = 0;
   int checks = 0;
   int cyc = 0;
   int starts = 0;
   int mreg[int];
   wire miso = spi_sdo_oe ? spi_sdo : 1'b1;
   tbm_top #(.CONV_CYCLES(CONV), .PERIOD_CYCLES(PER), .WINDOW_CYCLES(WIN)) u_tbm_top (.mclk(mclk), .rst_n(rst_n),
      .spi_sck(spi_sck), .spi_nsel(spi_nsel), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
      .conv_raw(conv_raw), .bat_raw(bat_raw), .test_bus_temp_sel(test_bus_temp_sel),
      .battery_monitor_enable(battery_monitor_enable), .battery_irq_enable(battery_irq_enable),
      .sleep_mode(sleep_mode), .conv_cfg(conv_cfg), .conv_start(conv_start), .temp_cfg(temp_cfg),
      .temp_sensor_power(temp_sensor_power), .battery_power(battery_power), .rc_osc_enable(rc_osc_enable),
      .irq_out_n(irq_out_n));
   tbm_host u_tbm_host (.mclk(mclk), .miso(miso), .spi_sck(spi_sck), .spi_nsel(spi_nsel), .spi_sdi(spi_sdi));
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc++;
      if (conv_start === 1'b1) starts++;
      if (cyc == 40000) begin
         num_errors++;
         results();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic results();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         $display("[ERR] %s expected %h seen %h", what, exp, got);
         num_errors++;
      end
   endtask
   // Model keeps the register image; refused writes leave it alone
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] unused;
      u_tbm_host.frame({1'b1, a}, d, unused);
      if (a == ADDR_BAT_THRESH) mreg[a] = {3'h0, d[4:0]};
      else if (a == ADDR_CONV_CFG) mreg[a] = {1'b0, d[6:0]};
      else if (a == ADDR_TEMP_CTL || a == ADDR_TEMP_OFFS) mreg[a] = d;
   endtask
   task automatic rd(input logic [6:0] a, input string what);
      logic [7:0] got;
      u_tbm_host.frame({1'b0, a}, 8'h00, got);
      chk(what, mreg.exists(a) ? 8'(mreg[a]) : 8'h00, got);
   endtask
   task automatic windows(input int n, input logic exp_irq);
      int len;
      time t0;
      for (int w = 0; w < n; w++) begin
         // Start on a fresh window, never in the middle of one
         wait (battery_power === 1'b0);
         wait (battery_power === 1'b1);
         if (w > 0) chk("period", 8'(PER), 8'(($time - t0) / 40));
         t0 = $time;
         len = 0;
         while (battery_power === 1'b1 && len < PER) begin
            tick(1);
            len++;
         end
         chk("window", 8'(WIN), 8'(len));
      end
      tick(2);
      chk("irq_out_n", {7'h00, exp_irq}, {7'h00, irq_out_n});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] off, raw, cfg, got;
      int exp;
      void'($urandom(32'hF5CF));
      mreg[ADDR_CONV_CFG] = RST_CONV_CFG;
      mreg[ADDR_CONV_VALUE] = RST_CONV_VALUE;
      mreg[ADDR_TEMP_CTL] = RST_TEMP_CTL;
      mreg[ADDR_TEMP_OFFS] = RST_TEMP_OFFS;
      mreg[ADDR_BAT_THRESH] = 8'h14;
      mreg[ADDR_BAT_LEVEL] = 8'h00;
      tick(3);
      rst_n = 1'b1;
      tick(3);
      chk("temp_cfg", 8'h20, temp_cfg);
      chk("sensor power", 8'h01, {7'h00, temp_sensor_power});
      foreach (mreg[a]) rd(a[6:0], "reset value");
      wr(ADDR_TEMP_OFFS, 8'($urandom));
      wr(ADDR_BAT_THRESH, 8'($urandom));
      wr(ADDR_BAT_LEVEL, 8'hFF);
      wr(ADDR_CONV_VALUE, 8'hFF);
      wr(7'h40, 8'hFF);
      foreach (mreg[a]) rd(a[6:0], "readback");
      rd(7'h40, "unmapped");
      cfg = 8'($urandom);
      off = 8'($urandom);
      u_tbm_host.frame2({1'b1, ADDR_TEMP_CTL}, cfg, off, got, raw);
      mreg[ADDR_TEMP_CTL] = cfg;
      mreg[ADDR_TEMP_OFFS] = off;
      u_tbm_host.frame2({1'b0, ADDR_TEMP_CTL}, 8'h00, 8'h00, got, raw);
      chk("burst temp ctl", cfg, got);
      chk("burst temp offset", off, raw);
      wr(ADDR_CONV_CFG, 8'h10);
      chk("sensor power", 8'h00, {7'h00, temp_sensor_power});
      test_bus_temp_sel = 1'b1;
      tick(3);
      chk("sensor power", 8'h01, {7'h00, temp_sensor_power});
      test_bus_temp_sel = 1'b0;
      // Every range, shift off once, saturating offset last
      for (int i = 0; i < 4; i++) begin
         off = (i == 3) ? 8'hF0 : 8'($urandom);
         raw = (i == 3) ? 8'h80 : 8'($urandom);
         conv_raw = raw;
         cfg = {2'(i), i != 2, 5'($urandom)};
         wr(ADDR_TEMP_CTL, cfg);
         chk("temp_cfg", cfg, temp_cfg);
         wr(ADDR_TEMP_OFFS, off);
         wr(ADDR_CONV_CFG, 8'h80);
         u_tbm_host.frame({1'b0, ADDR_CONV_CFG}, 8'h00, got);
         chk("busy read", 8'h80, got);
         wr(ADDR_CONV_CFG, 8'h80);
         for (int k = 0; k < CONV && conv_cfg.busy !== 1'b0; k++) tick(1);
         chk("busy", 8'h00, {7'h00, conv_cfg.busy});
         chk("starts", 8'(i + 1), 8'(starts));
         exp = cfg[5] ? raw + off : raw;
         mreg[ADDR_CONV_VALUE] = exp > 255 ? 255 : exp;
         rd(ADDR_CONV_VALUE, "conv value");
      end
      wr(ADDR_BAT_THRESH, 8'h10);
      bat_raw = 5'($urandom % 16);
      battery_irq_enable = 1'b1;
      battery_monitor_enable = 1'b1;
      windows(3, 1'b1);
      windows(1, 1'b0);
      mreg[ADDR_BAT_LEVEL] = bat_raw;
      rd(ADDR_BAT_LEVEL, "level");
      rd(7'h03, "status");
      bat_raw = 5'h10;
      windows(1, 1'b1);
      bat_raw = 5'h0F;
      windows(3, 1'b1);
      windows(1, 1'b0);
      battery_irq_enable = 1'b0;
      tick(2);
      chk("irq_out_n", 8'h01, {7'h00, irq_out_n});
      sleep_mode = 1'b1;
      tick(2);
      chk("rc osc", 8'h01, {7'h00, rc_osc_enable});
      battery_monitor_enable = 1'b0;
      tick(2);
      chk("rc osc", 8'h00, {7'h00, rc_osc_enable});
      exp = 0;
      for (int k = 0; k < 2 * PER; k++) begin
         tick(1);
         if (battery_power !== 1'b0) exp++;
      end
      chk("power off", 8'h00, 8'(exp));
      mreg[ADDR_BAT_LEVEL] = 5'h0F;
      rd(ADDR_BAT_LEVEL, "level kept");
      results();
   end
endmodule
